// [verilog/itq_defines.svh]
`ifndef ITQ_DEFINES_SVH
`define ITQ_DEFINES_SVH
// Register offsets (byte addresses, low eight address bits)
`define ITQ_OFS_ADDR   8'h00
`define ITQ_OFS_CTL    8'h04
`define ITQ_OFS_ACT    8'h08
`define ITQ_OFS_DATA   8'h0c
`define ITQ_OFS_IEN    8'h10
`define ITQ_OFS_RAW    8'h14
`define ITQ_OFS_MIS    8'h18
`define ITQ_OFS_IRQC   8'h1c
`define ITQ_OFS_TXCFG  8'h20
// Control word fields
`define ITQ_CTL_EN     0
`define ITQ_CTL_TXQ    1
`define ITQ_CTL_RXQ    2
// Interrupt control fields
`define ITQ_IRQC_EN    0
`define ITQ_IRQC_CLR   1
// Transmit queue configuration fields
`define ITQ_CFG_TGT    0
`define ITQ_CFG_DMA    1
`define ITQ_CFG_TRIG   4:2
`define ITQ_CFG_FLUSH  8
// Action status fields
`define ITQ_ACT_RREQ   0
`define ITQ_ACT_TREQ   1
`define ITQ_ACT_FBR    2
`define ITQ_ACT_ALT    3
`define ITQ_ACT_QCMD   4
`define ITQ_ACT_QBIT   5
// Sizes and reset values
`define ITQ_IRQ_W      9
`define ITQ_TXQ_DEPTH  4'h8
`define ITQ_RST_CFG    5'h00
`define ITQ_IDLE_BYTE  8'hff
`endif

// [verilog/itq_pkg.sv]
package itq_pkg;
    // Link engine states
    typedef enum logic [2:0] {
        ITQ_IDLE = 3'b000,
        ITQ_ADDR = 3'b001,
        ITQ_AACK = 3'b010,
        ITQ_RX   = 3'b011,
        ITQ_RACK = 3'b100,
        ITQ_TX   = 3'b101,
        ITQ_TACK = 3'b110
    } itq_state_type;
    // Interrupt sources, bit 8 down to bit 0
    typedef struct packed {
        logic rx_full;
        logic tx_empty;
        logic rx_req;
        logic tx_req;
        logic tx_dma_done;
        logic rx_dma_done;
        logic stop;
        logic start;
        logic data;
    } itq_irq_type;
endpackage

// [verilog/itq_target.sv]
// Summary of operation
// - Clear-all write drops target interrupt output
// - Write-one mask clears selected sources only
// - Per-source enable gates the interrupt output
// - Nine sources, receive/transmit queue, DMA, start, stop
// - Raw and masked status both readable
// - Report idle, receive request, transmit request
// - Flag first byte after own address
// - Report second own address match
// - Report quick command and its data bit
// - Transmit queue has exactly one owner
// - Configure owner and DMA or processor service
// - Trigger level one to eight drives requests
// - Flush control empties transmit queue
// - Global enable for the target interrupt
// - Control word write-only, replaced whole
//
// Chosen here: the APB slave port and the address map.
`include "itq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module itq_target
    import itq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Bus pins, open drain
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe,
    // Receive queue and DMA events
    input  wire logic        rx_full_ev,
    input  wire logic        rx_req_ev,
    input  wire logic        rx_dma_done,
    input  wire logic        tx_dma_done,
    // Transmit DMA channel
    input  wire logic        tx_dma_valid,
    input  wire logic [7:0]  tx_dma_data,
    output var  logic        tx_dma_req,
    // Master function side of the queue
    input  wire logic        mst_tx_pop,
    output var  logic [7:0]  mst_tx_data,
    // Status out
    output var  logic        rx_fifo_en,
    output var  logic        irq
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [6:0]    own_prim;       // Primary own address
    logic [6:0]    own_alt;        // Second own address
    logic          alt_en;         // Second address in use
    logic          tgt_en;         // Target enabled
    logic          txq_en;         // Target uses transmit queue
    itq_irq_type   ien;            // Per-source enables
    itq_irq_type   raw;            // Sticky raw status
    itq_irq_type   mis;            // Masked status
    itq_irq_type   ev;             // Event pulses
    logic          gen;            // Global interrupt enable
    logic          own_tgt;        // Queue owned by target
    logic          use_dma;        // Queue serviced by DMA
    logic [2:0]    trig;           // Trigger level minus one
    logic [5:0]    act;            // Action status
    logic [7:0]    rx_byte;        // Last received byte
    logic [7:0]    mem [0:7];      // Transmit queue storage
    logic [2:0]    wp;             // Write index
    logic [2:0]    rp;             // Read index
    logic [3:0]    cnt;            // Fill count
    logic          scl_m, scl_s, scl_d;
    logic          sda_m, sda_s, sda_d;
    itq_state_type st;             // Link engine state
    logic [3:0]    bits;           // Bits seen in this byte
    logic [7:0]    sh;             // Receive shifter
    logic [7:0]    txsh;           // Transmit shifter
    logic          rw, nack, first, qc, alt_hit;
    logic          ev_rx, ev_fbr, ev_treq, ev_addr, ev_qc;
    logic          ev_start, ev_stop, tgt_pop;
    logic          txe_d, txr_d;   // Previous queue levels

    ////////////////////////////////////////////////////////////////////
    // Bus decode and queue control terms
    logic wr, rd, push, pop, flush, have, txe, txr;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] tx_next;
    assign wr    = psel & penable & pwrite;
    assign rd    = psel & penable & ~pwrite;
    assign flush = wr && paddr == `ITQ_OFS_TXCFG
                   && pwdata[`ITQ_CFG_FLUSH];
    // Processor pushes only when DMA is off, DMA only when on
    assign push  = (use_dma ? tx_dma_valid
                    : wr && paddr == `ITQ_OFS_DATA)
                   && cnt != `ITQ_TXQ_DEPTH;
    // Only the current owner may drain the queue
    assign pop   = (own_tgt ? tgt_pop : mst_tx_pop)
                   && cnt != 4'h0;
    assign have  = txq_en & own_tgt & (cnt != 4'h0);
    assign tx_next = have ? mem[rp] : `ITQ_IDLE_BYTE;
    assign txe   = own_tgt & (cnt == 4'h0);
    // Request at or below the trigger level, whoever owns the queue
    assign txr   = cnt <= {1'b0, trig} + 4'h1;
    // Pin edges, read only from the second and third stages
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_c  = scl_s & scl_d & ~sda_s & sda_d;
    assign stop_c   = scl_s & scl_d & sda_s & ~sda_d;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link engine: address match, acknowledge, byte shifting
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= ITQ_IDLE;
            bits <= 4'h0;
            sh <= 8'h00;
            txsh <= 8'h00;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            {rw, nack, first, qc, alt_hit} <= 5'h00;
            {ev_rx, ev_fbr, ev_treq, ev_addr, ev_qc} <= 5'h00;
            {ev_start, ev_stop, tgt_pop} <= 3'h0;
            rx_byte <= 8'h00;
        end else begin
            {ev_rx, ev_fbr, ev_treq, ev_addr, ev_qc} <= 5'h00;
            {ev_start, ev_stop, tgt_pop} <= 3'h0;
            if (!tgt_en) begin
                // Disabled target lets go of the line at once
                st <= ITQ_IDLE;
                sda_oe <= 1'b0;
            end else if (start_c) begin
                st <= ITQ_ADDR;
                bits <= 4'h0;
                sda_oe <= 1'b0;
                qc <= 1'b0;
                ev_start <= 1'b1;
            end else if (stop_c) begin
                st <= ITQ_IDLE;
                sda_oe <= 1'b0;
                ev_stop <= 1'b1;
                ev_qc <= qc;
                qc <= 1'b0;
            end else if (scl_rise) begin
                if (st == ITQ_ADDR || st == ITQ_RX) begin
                    sh <= {sh[6:0], sda_s};
                    bits <= bits + 4'h1;
                end else if (st == ITQ_TX) begin
                    bits <= bits + 4'h1;
                end else if (st == ITQ_TACK) begin
                    nack <= sda_s;
                end
            end else if (scl_fall) begin
                case (st)
                    ITQ_ADDR: if (bits == 4'h8) begin
                        bits <= 4'h0;
                        if (sh[7:1] == own_prim ||
                            (alt_en && sh[7:1] == own_alt)) begin
                            st <= ITQ_AACK;
                            sda_oe <= 1'b1;
                            rw <= sh[0];
                            alt_hit <= sh[7:1] != own_prim;
                        end else begin
                            st <= ITQ_IDLE;
                        end
                    end
                    ITQ_AACK: begin
                        first <= 1'b1;
                        qc <= 1'b1;
                        ev_addr <= 1'b1;
                        if (rw) begin
                            st <= ITQ_TX;
                            txsh <= tx_next;
                            sda_oe <= ~tx_next[7];
                            tgt_pop <= have;
                            ev_treq <= 1'b1;
                        end else begin
                            st <= ITQ_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                    ITQ_RX: if (bits == 4'h8) begin
                        bits <= 4'h0;
                        st <= ITQ_RACK;
                        sda_oe <= 1'b1;
                        qc <= 1'b0;
                        rx_byte <= sh;
                        ev_rx <= 1'b1;
                        ev_fbr <= first;
                        first <= 1'b0;
                    end
                    ITQ_RACK: begin
                        st <= ITQ_RX;
                        sda_oe <= 1'b0;
                    end
                    ITQ_TX: if (bits == 4'h8) begin
                        bits <= 4'h0;
                        st <= ITQ_TACK;
                        sda_oe <= 1'b0;
                        qc <= 1'b0;
                    end else begin
                        txsh <= {txsh[6:0], 1'b0};
                        sda_oe <= ~txsh[6];
                    end
                    ITQ_TACK: if (nack) begin
                        st <= ITQ_IDLE;
                    end else begin
                        st <= ITQ_TX;
                        txsh <= tx_next;
                        sda_oe <= ~tx_next[7];
                        tgt_pop <= have;
                        ev_treq <= 1'b1;
                    end
                    default: st <= ITQ_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit queue storage and pointers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wp <= 3'h0;
            rp <= 3'h0;
            cnt <= 4'h0;
            mst_tx_data <= 8'h00;
            tx_dma_req <= 1'b0;
            {txe_d, txr_d} <= 2'h0;
        end else begin
            if (flush) begin
                // Flush beats any push or pop in the same cycle
                wp <= 3'h0;
                rp <= 3'h0;
                cnt <= 4'h0;
            end else begin
                if (push) begin
                    mem[wp] <= use_dma ? tx_dma_data : pwdata[7:0];
                    wp <= wp + 3'h1;
                end
                if (pop) begin
                    rp <= rp + 3'h1;
                end
                cnt <= cnt + {3'h0, push} - {3'h0, pop};
            end
            mst_tx_data <= own_tgt ? 8'h00 : mem[rp];
            tx_dma_req <= use_dma & txr;
            {txe_d, txr_d} <= {txe, txr};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event vector; queue levels raise on their rising edge only
    always_comb begin
        ev = '0;
        ev.rx_full     = rx_full_ev;
        ev.tx_empty    = txe & ~txe_d;
        ev.rx_req      = rx_req_ev;
        ev.tx_req      = txr & ~txr_d & ~use_dma;
        ev.tx_dma_done = tx_dma_done;
        ev.rx_dma_done = rx_dma_done;
        ev.stop        = ev_stop;
        ev.start       = ev_start;
        ev.data        = ev_rx | ev_treq;
    end
    assign mis = raw & ien;

    ////////////////////////////////////////////////////////////////////
    // Sticky interrupt status; a new event beats its own clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            raw <= '0;
            irq <= 1'b0;
        end else begin
            if (wr && paddr == `ITQ_OFS_IRQC
                && pwdata[`ITQ_IRQC_CLR])
                raw <= ev;
            else if (wr && paddr == `ITQ_OFS_RAW)
                raw <= (raw & ~pwdata[8:0]) | ev;
            else
                raw <= raw | ev;
            // Follows status one cycle later
            irq <= gen & (|mis);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Action status; each flag's set wins over its clear
    logic [5:0] act_set, act_clr;
    always_comb begin
        act_set = 6'h00;
        act_set[`ITQ_ACT_RREQ] = ev_rx;
        act_set[`ITQ_ACT_FBR]  = ev_fbr;
        act_set[`ITQ_ACT_TREQ] = ev_treq;
        act_set[`ITQ_ACT_ALT]  = ev_addr & alt_hit;
        act_set[`ITQ_ACT_QCMD] = ev_qc;
        act_set[`ITQ_ACT_QBIT] = ev_qc & rw;
        act_clr = 6'h00;
        // Reading the data takes the receive flags down
        if (rd && paddr == `ITQ_OFS_DATA) begin
            act_clr[`ITQ_ACT_RREQ] = 1'b1;
            act_clr[`ITQ_ACT_FBR]  = 1'b1;
        end
        if (wr && paddr == `ITQ_OFS_DATA)
            act_clr[`ITQ_ACT_TREQ] = 1'b1;
        // Reading the action word consumes one-shot reports
        if (rd && paddr == `ITQ_OFS_ACT) begin
            act_clr[`ITQ_ACT_ALT]  = 1'b1;
            act_clr[`ITQ_ACT_QCMD] = 1'b1;
            act_clr[`ITQ_ACT_QBIT] = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn)
            act <= 6'h00;
        else
            act <= (act & ~act_clr) | act_set;
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes, taken in the access phase
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {alt_en, own_alt, own_prim} <= 15'h0000;
            {tgt_en, txq_en, rx_fifo_en} <= 3'h0;
            ien <= '0;
            gen <= 1'b0;
            {trig, use_dma, own_tgt} <= `ITQ_RST_CFG;
        end else if (wr) begin
            if (paddr == `ITQ_OFS_ADDR) begin
                own_prim <= pwdata[6:0];
                own_alt <= pwdata[14:8];
                alt_en <= pwdata[15];
            end else if (paddr == `ITQ_OFS_CTL) begin
                // Whole word replaces every setting at once
                tgt_en <= pwdata[`ITQ_CTL_EN];
                txq_en <= pwdata[`ITQ_CTL_TXQ];
                rx_fifo_en <= pwdata[`ITQ_CTL_RXQ];
            end else if (paddr == `ITQ_OFS_IEN) begin
                ien <= pwdata[8:0];
            end else if (paddr == `ITQ_OFS_IRQC) begin
                gen <= pwdata[`ITQ_IRQC_EN];
            end else if (paddr == `ITQ_OFS_TXCFG) begin
                own_tgt <= pwdata[`ITQ_CFG_TGT];
                use_dma <= pwdata[`ITQ_CFG_DMA];
                trig <= pwdata[`ITQ_CFG_TRIG];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data captured in setup; no wait states
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
                if (paddr == `ITQ_OFS_ADDR)
                    prdata <= {16'h0000, alt_en, own_alt, 1'b0, own_prim};
                else if (paddr == `ITQ_OFS_CTL)
                    prdata <= 32'h0000_0000;
                else if (paddr == `ITQ_OFS_ACT)
                    prdata <= {26'h0000000, act};
                else if (paddr == `ITQ_OFS_DATA)
                    prdata <= {24'h000000, rx_byte};
                else if (paddr == `ITQ_OFS_IEN)
                    prdata <= {23'h000000, ien};
                else if (paddr == `ITQ_OFS_RAW)
                    prdata <= {23'h000000, raw};
                else if (paddr == `ITQ_OFS_MIS)
                    prdata <= {23'h000000, mis};
                else if (paddr == `ITQ_OFS_IRQC)
                    prdata <= {31'h00000000, gen};
                else if (paddr == `ITQ_OFS_TXCFG)
                    prdata <= {12'h000, cnt, 11'h000,
                               trig, use_dma, own_tgt};
                else
                    pslverr <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/itq_target_props.sv]
`timescale 1ns/1ps
`default_nettype none
module itq_target_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Events, queue and status
    input wire logic        rx_full_ev,
    input wire logic        rx_req_ev,
    input wire logic        rx_dma_done,
    input wire logic        tx_dma_done,
    input wire logic        tx_dma_valid,
    input wire logic        tx_dma_req,
    input wire logic [7:0]  mst_tx_data,
    input wire logic        rx_fifo_en,
    input wire logic        irq
);
    ////////////////////////////////////////////////////////////////
    // Bus phases
    wire setup = psel && !penable;
    wire wr    = psel && penable && pwrite;
    wire quiet = !(rx_full_ev || rx_req_ev || rx_dma_done || tx_dma_done);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    ready_zero_wait_a: assert property (setup |=> pready)
        else $error("pready missing in access cycle");
    unmapped_err_a: assert property (setup && paddr > 8'h20 |=> pslverr)
        else $error("unmapped address not refused");
    clear_all_a: assert property (
        wr && paddr == 8'h1c && pwdata[1] && quiet |-> ##2 !irq)
        else $error("irq stays after clear-all");
    global_off_a: assert property (
        wr && paddr == 8'h1c && !pwdata[0] |-> ##2 !irq)
        else $error("irq while global enable off");
    enable_off_a: assert property (
        wr && paddr == 8'h10 && pwdata[8:0] == 9'h000 |-> ##2 !irq)
        else $error("irq with every source disabled");
    ctl_reads_zero_a: assert property (
        setup && !pwrite && paddr == 8'h04 |=> prdata == 32'h0)
        else $error("control word readable");
    ctl_replace_a: assert property (
        wr && paddr == 8'h04 |-> ##2 rx_fifo_en == $past(pwdata[2], 2))
        else $error("rx queue enable not replaced");
    owner_zero_a: assert property (
        wr && paddr == 8'h20 && pwdata[0] |-> ##2 mst_tx_data == 8'h00)
        else $error("master side sees target queue");
    flush_dma_a: assert property (
        wr && paddr == 8'h20 && pwdata[8] && pwdata[1] && !tx_dma_valid
        |-> ##2 tx_dma_req)
        else $error("no DMA request after flush");
    // Main scenarios reached
    cover property (wr && paddr == 8'h1c && pwdata[1]);
    cover property (wr && paddr == 8'h20 && pwdata[8]);
    cover property ($rose(irq));
endmodule
`default_nettype wire

// [tb/itq_i2c_master.sv]
`timescale 1ns/1ps
`default_nettype none
module itq_i2c_master (
    // Target pulls SDA low while high
    input  wire logic sda_oe,
    // Bus wires, SDA pulled up
    output var  logic scl,
    output wire logic sda
);
    logic pull_low; // Master holds SDA low
    assign sda = !(pull_low || sda_oe);
    // SCL stands high outside frames
    initial begin
        scl      = 1'b1;
        pull_low = 1'b0;
    end
    // Offset of 2 ns keeps pin edges clear of clock edges
    task automatic start_bit();
        #2 pull_low = 1'b1;
        #32 scl = 1'b0;
        #16;
    endtask
    // Data set in the low phase, sampled mid high phase
    task automatic bit_out(input logic b, output logic seen);
        pull_low = !b;
        #16 scl = 1'b1;
        #16 seen = sda;
        #16 scl = 1'b0;
        #16;
    endtask
    // Address or data byte, MSB first, then ACK slot
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(v[i], s);
        bit_out(1'b1, s);
        ack = !s;
    endtask
    // Stop: SDA rises while SCL high
    task automatic stop_bit();
        pull_low = 1'b1;
        #16 scl = 1'b1;
        #16 pull_low = 1'b0;
        #32;
    endtask
endmodule
`default_nettype wire

// [tb/tb_itq_target.sv]
`include "itq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_itq_target;
    // Clock, reset and APB
    logic        clk, resetn, psel, penable, pwrite, err, ack;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr;
    // Pins, events and queue ports
    logic        scl, sda, sda_o, sda_oe, tx_dma_valid, tx_dma_req;
    logic [3:0]  ev;
    logic [7:0]  tx_dma_data, mst_tx_data;
    logic        mst_tx_pop, rx_fifo_en, irq;
    int          fail_count, total_checks, cycles;
    ////////////////////////////////////////////////////////////////
    itq_target i_dut (.*, .scl_i(scl), .sda_i(sda),
        .rx_full_ev(ev[0]), .rx_req_ev(ev[1]),
        .rx_dma_done(ev[2]), .tx_dma_done(ev[3]));
    itq_i2c_master i_mst (.sda_oe(sda_oe), .scl(scl), .sda(sda));
    ////////////////////////////////////////////////////////////////
    // APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One-cycle event pulses
    task automatic evp(input logic [3:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h got %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_irq();
        apb(1, `ITQ_OFS_IRQC, 32'h3);
        apb(1, `ITQ_OFS_IEN, 32'h0);
        evp(4'hf);
        apb(0, `ITQ_OFS_RAW, 0);
        chk("raw", 32'h158, rd & 32'h158);
        apb(0, `ITQ_OFS_MIS, 0);
        chk("mis off", 32'h0, rd);
        chk("irq off", 32'h0, irq);
        apb(1, `ITQ_OFS_IEN, 32'h100);
        idle(2);
        chk("irq on", 32'h1, irq);
        apb(0, `ITQ_OFS_MIS, 0);
        chk("mis on", 32'h100, rd);
        apb(1, `ITQ_OFS_IRQC, 32'h0);
        idle(2);
        chk("irq gated", 32'h0, irq);
        apb(1, `ITQ_OFS_IRQC, 32'h1);
        apb(1, `ITQ_OFS_RAW, 32'h58);
        apb(0, `ITQ_OFS_RAW, 0);
        chk("raw w1c", 32'h100, rd & 32'h158);
        chk("irq kept", 32'h1, irq);
        apb(1, `ITQ_OFS_RAW, 32'h100);
        idle(2);
        chk("irq w1c", 32'h0, irq);
        evp(4'h1);
        idle(2);
        chk("irq again", 32'h1, irq);
        // Handler clears first thing
        apb(1, `ITQ_OFS_IRQC, 32'h3);
        idle(2);
        chk("irq clear", 32'h0, irq);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_link();
        apb(0, 8'h40, 0);
        chk("slverr", 32'h1, err);
        apb(1, `ITQ_OFS_ADDR, 32'ha53b);
        apb(1, `ITQ_OFS_CTL, 32'h1);
        apb(1, `ITQ_OFS_CTL, 32'h0);
        chk("ctl read", 32'h0, rd);
        i_mst.start_bit();
        i_mst.send_byte(8'h76, ack);
        i_mst.stop_bit();
        @(posedge clk);
        chk("ack disabled", 32'h0, ack);
        apb(1, `ITQ_OFS_CTL, 32'h5);
        idle(1);
        chk("rx en", 32'h1, rx_fifo_en);
        i_mst.start_bit();
        i_mst.send_byte(8'h76, ack);
        chk("ack addr", 32'h1, ack);
        i_mst.send_byte(8'h51, ack);
        chk("ack data", 32'h1, ack);
        i_mst.stop_bit();
        @(posedge clk);
        apb(0, `ITQ_OFS_ACT, 0);
        chk("act recv", 32'h5, rd & 32'h7);
        apb(0, `ITQ_OFS_RAW, 0);
        chk("link raw", 32'h7, rd & 32'h7);
        apb(0, `ITQ_OFS_DATA, 0);
        chk("rx byte", 32'h51, rd & 32'hff);
        apb(0, `ITQ_OFS_ACT, 0);
        chk("act idle", 32'h0, rd & 32'h7);
        i_mst.start_bit();
        i_mst.send_byte(8'h4b, ack);
        i_mst.stop_bit();
        @(posedge clk);
        chk("ack alt", 32'h1, ack);
        apb(0, `ITQ_OFS_ACT, 0);
        chk("quick", 32'h38, rd & 32'h38);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_txq();
        apb(1, `ITQ_OFS_TXCFG, 32'h4);
        apb(1, `ITQ_OFS_DATA, 32'h11);
        apb(1, `ITQ_OFS_DATA, 32'h22);
        apb(1, `ITQ_OFS_DATA, 32'h33);
        apb(0, `ITQ_OFS_TXCFG, 0);
        chk("fill", 32'h30000, rd & 32'hf0000);
        chk("head", 32'h11, {24'h0, mst_tx_data});
        apb(1, `ITQ_OFS_RAW, 32'h1ff);
        mst_tx_pop <= 1'b1;
        @(posedge clk);
        mst_tx_pop <= 1'b0;
        idle(3);
        chk("head pop", 32'h22, {24'h0, mst_tx_data});
        apb(0, `ITQ_OFS_RAW, 0);
        chk("tx req", 32'h20, rd & 32'h20);
        chk("dma idle", 32'h0, tx_dma_req);
        apb(1, `ITQ_OFS_TXCFG, 32'h106);
        idle(1);
        chk("dma req", 32'h1, tx_dma_req);
        apb(0, `ITQ_OFS_TXCFG, 0);
        chk("flushed", 32'h0, rd & 32'hf0000);
        repeat (3) begin
            tx_dma_valid <= 1'b1;
            tx_dma_data  <= 8'ha5;
            @(posedge clk);
            tx_dma_valid <= 1'b0;
            @(posedge clk);
        end
        idle(2);
        chk("dma above", 32'h0, tx_dma_req);
        apb(1, `ITQ_OFS_TXCFG, 32'h7);
        idle(1);
        chk("owner", 32'h0, {24'h0, mst_tx_data});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        {resetn, psel, penable, pwrite, mst_tx_pop, tx_dma_valid} = 6'h0;
        {paddr, pwdata, ev, tx_dma_data} = 52'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        test_irq();
        test_link();
        test_txq();
        print_verdict();
    end
endmodule
bind itq_target itq_target_props i_props (.*);
`default_nettype wire
